// File: rtl/srg_pkg.sv
package srg_pkg;

    // Inter-step delay counter width and move length width.
    localparam int DLY_W = 16;
    localparam int STP_W = 24;
    localparam int POS_W = 32;

    // Reference clock and the fixed tick that times every step delay.
    localparam int REF_CLK_HZ = 20_000_000;
    localparam int TICK_HZ    = 1_000_000;
    localparam int TICK_DIV   = REF_CLK_HZ / TICK_HZ;

    // First-delay compensation factor, 0.676 as a ratio.
    localparam int COMP_NUM = 676;
    localparam int COMP_DEN = 1000;

    // Winding pattern per half-step position, {a_pos, a_neg, b_pos, b_neg}, entry 0 in the low nibble.
    // Order: A+, A+B+, B+, A-B+, A-, A-B-, B-, A+B-; even entries are the full-step positions.
    localparam logic [31:0] WIND_TABLE = 32'h915462a8;

    // Profile states of the ramp sequencer.
    typedef enum logic [1:0] {
        SRG_IDLE,
        SRG_ACCEL,
        SRG_RUN,
        SRG_DECEL
    } srg_fsm_type;

endpackage

// File: rtl/srg_step_gen.sv
// Operation
// R01: Drive mode input selects full-step or half-step winding sequencing.
// R02: Full-step walks four single-winding positions: A+, B+, A-, B-.
// R03: Half-step walks eight positions alternating single and double winding drive.
// R04: Each step pulse moves the pattern one position; direction sets the walking order.
// R05: Step delays are counted in ticks of a fixed tick frequency.
// R06: The inter-step delay counter is 16 bits wide.
// R07: Constant-speed motion reloads the same delay count for every step.
// R08: First ramp delay equals tick frequency times sqrt of twice angle over acceleration.
// R09: Each ramp delay is previous minus twice previous over (4n+1).
// R10: The first delay is scaled by 0.676 to correct the approximation.
// R11: An acceleration change mid-ramp rescales n so n times acceleration stays constant.
// R12: Deceleration starts at step n1 = total times decel over accel plus decel.
// R13: A signed position counter follows every step in the commanded direction.
// R14: Mode and direction change only while no move is in progress.
`timescale 1ns/1ns
module srg_step_gen #(
    parameter int TICK_DIV = srg_pkg::TICK_DIV
) (
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    input  wire logic                        start,
    input  wire logic                        half_step,
    input  wire logic                        dir,
    input  wire logic                        constant_mode,
    input  wire logic [srg_pkg::STP_W-1:0]   move_steps,
    input  wire logic [15:0]                 accel,
    input  wire logic [15:0]                 decel,
    input  wire logic [srg_pkg::DLY_W-1:0]   first_delay,
    input  wire logic [srg_pkg::DLY_W-1:0]   min_delay,
    output logic                             step_pulse,
    output logic                             wind_a_pos,
    output logic                             wind_a_neg,
    output logic                             wind_b_pos,
    output logic                             wind_b_neg,
    output logic signed [srg_pkg::POS_W-1:0] position,
    output logic [srg_pkg::DLY_W-1:0]        step_delay,
    output logic                             busy
);

    typedef struct packed {
        srg_pkg::srg_fsm_type             fsm;
        logic                             half;
        logic                             dir;
        logic [2:0]                       phase;
        logic [3:0]                       wind;
        logic                             step;
        logic signed [srg_pkg::POS_W-1:0] pos;
        // R06 16-bit delay counter
        logic [srg_pkg::DLY_W-1:0]        cnt;
        logic [srg_pkg::DLY_W-1:0]        delay;
        logic [15:0]                      tick;
        logic signed [srg_pkg::STP_W-1:0] idx;
        logic [srg_pkg::STP_W-1:0]        done;
        logic [srg_pkg::STP_W-1:0]        total;
        logic [srg_pkg::STP_W-1:0]        n1;
        logic [15:0]                      acc;
        logic [15:0]                      dec;
    } srg_state_type;

    srg_state_type                    s;
    srg_state_type                    next_s;
    logic                             tick_now;
    logic                             step_now;
    logic signed [srg_pkg::STP_W-1:0] idx_inc;
    logic signed [srg_pkg::STP_W-1:0] ramp_n;
    logic signed [25:0]               ramp_den;
    logic signed [25:0]               ramp_quot;
    logic signed [25:0]               ramp_sum;
    logic [srg_pkg::DLY_W-1:0]        ramp_c;
    logic [31:0]                      c0_wide;
    logic [srg_pkg::DLY_W-1:0]        c0_scaled;
    logic [39:0]                      n1_wide;
    logic [39:0]                      dec_len;
    logic [39:0]                      idx_rescaled;
    logic [2:0]                       phase_inc;

    // Tick divider and step moment; the step fires on the tick that ends the loaded count.
    assign tick_now = (s.tick == 16'(TICK_DIV - 1));
    assign step_now = (s.fsm != srg_pkg::SRG_IDLE) && tick_now && (s.cnt <= 16'h0001);

    // R09 ramp recurrence
    assign idx_inc   = s.idx + 24'sh000001;
    assign ramp_n    = (s.fsm == srg_pkg::SRG_ACCEL) ? idx_inc : s.idx;
    assign ramp_den  = $signed({ramp_n, 2'b00}) + 26'sh0000001;
    assign ramp_quot = $signed({9'h000, s.delay, 1'b0}) / ramp_den;
    assign ramp_sum  = $signed({10'h000, s.delay}) - ramp_quot;
    // The divisor is never zero because 4n+1 is odd; the clamp keeps a runaway ramp inside 16 bits.
    assign ramp_c    = (ramp_sum < 26'sh0000001) ? 16'h0001 :
                       (ramp_sum > 26'sh000ffff) ? 16'hffff : ramp_sum[15:0];

    // R10 first delay scaling
    assign c0_wide   = ({16'h0000, first_delay} * 32'(srg_pkg::COMP_NUM)) / 32'(srg_pkg::COMP_DEN);
    assign c0_scaled = (c0_wide[31:16] != 16'h0000) ? 16'hffff :
                       (c0_wide[15:0] == 16'h0000) ? 16'h0001 : c0_wide[15:0];

    // R12 deceleration start point
    assign n1_wide = ((accel == 16'h0000) && (decel == 16'h0000)) ? {16'h0000, move_steps} :
                     ({16'h0000, move_steps} * {24'h000000, decel}) /
                     ({24'h000000, accel} + {24'h000000, decel});

    // Steps that deceleration needs from the speed reached, by the same n times rate product.
    assign dec_len = (s.dec == 16'h0000) ? 40'h0000000000 :
                     ({16'h0000, idx_inc} * {24'h000000, s.acc}) / {24'h000000, s.dec};

    // R11 index rescale
    assign idx_rescaled = (accel == 16'h0000) ? {16'h0000, s.idx} :
                          ({16'h0000, s.idx} * {24'h000000, s.acc}) / {24'h000000, accel};

    // R01 mode step size
    assign phase_inc = s.half ? 3'h1 : 3'h2;

    // Next-state logic for the whole sequencer.
    always_comb begin
        next_s      = s;
        next_s.step = 1'b0;
        next_s.tick = tick_now ? 16'h0000 : s.tick + 16'h0001;
        if (s.fsm == srg_pkg::SRG_IDLE) begin
            if (start && (move_steps != 24'h000000)) begin
                // R14 latch mode
                next_s.half  = half_step;
                next_s.dir   = dir;
                // R02 full-step alignment
                next_s.phase = half_step ? s.phase : {s.phase[2:1], 1'b0};
                next_s.total = move_steps;
                next_s.done  = 24'h000000;
                next_s.idx   = 24'sh000000;
                next_s.acc   = accel;
                next_s.dec   = decel;
                next_s.tick  = 16'h0000;
                if (constant_mode) begin
                    // R07 constant rate start
                    next_s.fsm   = srg_pkg::SRG_RUN;
                    next_s.delay = min_delay;
                    next_s.n1    = move_steps;
                end else begin
                    // R08 first delay load
                    next_s.fsm   = srg_pkg::SRG_ACCEL;
                    next_s.delay = c0_scaled;
                    next_s.n1    = n1_wide[23:0];
                end
                next_s.cnt = next_s.delay;
            end
        end else if (step_now) begin
            next_s.step = 1'b1;
            // R04 pattern advance
            next_s.phase = s.dir ? s.phase + phase_inc : s.phase - phase_inc;
            // R13 position count
            next_s.pos  = s.dir ? s.pos + 32'sh00000001 : s.pos - 32'sh00000001;
            next_s.done = s.done + 24'h000001;
            if (next_s.done == s.total) begin
                next_s.fsm = srg_pkg::SRG_IDLE;
            end else begin
                case (s.fsm)
                    srg_pkg::SRG_ACCEL: begin
                        next_s.idx = idx_inc;
                        if (ramp_c <= min_delay) begin
                            next_s.delay = min_delay;
                            next_s.fsm   = srg_pkg::SRG_RUN;
                            next_s.n1    = (dec_len >= {16'h0000, s.total}) ? next_s.done :
                                           s.total - dec_len[23:0];
                        end else begin
                            next_s.delay = ramp_c;
                        end
                    end
                    srg_pkg::SRG_RUN: begin
                        // R07 constant reload
                        next_s.delay = min_delay;
                    end
                    srg_pkg::SRG_DECEL: begin
                        next_s.idx   = idx_inc;
                        next_s.delay = ramp_c;
                    end
                    default: begin
                        next_s.fsm = srg_pkg::SRG_IDLE;
                    end
                endcase
                // R12 enter deceleration
                if ((next_s.fsm != srg_pkg::SRG_DECEL) && (next_s.done >= next_s.n1)) begin
                    next_s.fsm = srg_pkg::SRG_DECEL;
                    next_s.idx = $signed(next_s.done - s.total);
                end
            end
            // R05 reload counter
            next_s.cnt = next_s.delay;
        end else begin
            if (tick_now) begin
                next_s.cnt = s.cnt - 16'h0001;
            end
            // R11 acceleration change
            if ((s.fsm == srg_pkg::SRG_ACCEL) && (accel != s.acc) && (accel != 16'h0000)) begin
                next_s.idx = $signed(idx_rescaled[23:0]);
                next_s.acc = accel;
            end
        end
        // R03 pattern lookup
        next_s.wind = srg_pkg::WIND_TABLE[{next_s.phase, 2'b00} +: 4];
    end

    // State register; reset leaves the sequencer idle at phase 0.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs all come straight from the state register.
    assign step_pulse = s.step;
    assign wind_a_pos = s.wind[3];
    assign wind_a_neg = s.wind[2];
    assign wind_b_pos = s.wind[1];
    assign wind_b_neg = s.wind[0];
    assign position   = s.pos;
    assign step_delay = s.delay;
    assign busy       = (s.fsm != srg_pkg::SRG_IDLE);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_full_one_wind: assert property (busy && !s.half |-> $onehot(s.wind)) // R02
        else $error("Full-step drive energizes other than one winding.");

    a_half_pattern: assert property (s.step && s.half |-> $onehot(s.wind) != $onehot($past(s.wind))) // R03
        else $error("Half-step drive did not alternate single and double winding.");

    a_phase_walk: assert property (s.step |-> s.phase == $past(s.phase) + (s.dir ? phase_inc : -phase_inc)) // R04
        else $error("Pattern did not advance one position in the set direction.");

    a_step_spacing: assert property (s.step |=> !s.step [*8]) // R05
        else $error("Step pulses closer than one tick period.");

    a_tick_hold: assert property (busy && !tick_now |=> $stable(s.cnt)) // R05
        else $error("Delay counter moved without a tick.");

    a_const_reload: assert property (s.step && s.fsm == srg_pkg::SRG_RUN && $past(s.fsm) == srg_pkg::SRG_RUN // R07
                                     |-> s.delay == min_delay)
        else $error("Constant-speed step did not reload the same delay.");

    a_first_delay: assert property (!busy && start && move_steps != 24'h000000 && !constant_mode // R10
                                    |=> s.delay == $past(c0_scaled) && s.cnt == s.delay)
        else $error("Ramp did not start from the scaled first delay.");

    a_ramp_drop: assert property (s.step && s.fsm == srg_pkg::SRG_ACCEL && $past(s.fsm) == srg_pkg::SRG_ACCEL // R09
                                  |-> s.delay <= $past(s.delay))
        else $error("Acceleration ramp lengthened the delay.");

    a_decel_rise: assert property (s.step && s.fsm == srg_pkg::SRG_DECEL && $past(s.fsm) == srg_pkg::SRG_DECEL // R09
                                   |-> s.delay >= $past(s.delay))
        else $error("Deceleration ramp shortened the delay.");

    // The rescaled index is the largest n whose product with the new rate stays within the old product.
    a_accel_rescale: assert property (s.fsm == srg_pkg::SRG_ACCEL && !step_now && accel != s.acc // R11
                                      && accel != 16'h0000
                                      |=> s.acc == $past(accel)
                                      && 40'(s.idx) * 40'(s.acc) <= 40'($past(s.idx)) * 40'($past(s.acc))
                                      && 40'(s.idx + 24'sh000001) * 40'(s.acc) > 40'($past(s.idx)) * 40'($past(s.acc)))
        else $error("Acceleration change did not keep index times rate.");

    a_pos_count: assert property (s.step |-> s.pos == $past(s.pos) + (s.dir ? 32'sh00000001 : -32'sh00000001)) // R13
        else $error("Position did not follow the step.");

    a_mode_hold: assert property (busy && $past(busy) |-> $stable(s.half) && $stable(s.dir)) // R14
        else $error("Mode or direction changed during a move.");

endmodule

// File: verification/srg_motor_model.sv
`timescale 1ns/1ns
// Two-winding motor behind its bridge: it turns the four drive lines into the rotor's electrical position.
module srg_motor_model (
    input  wire logic       a_pos,
    input  wire logic       a_neg,
    input  wire logic       b_pos,
    input  wire logic       b_neg,
    output logic [2:0]      phase,
    output logic            legal
);
    // winding positions
    // Both sides of one bridge on at once would short it, so such a pattern is flagged illegal.
    always_comb begin
        legal = 1'b1;
        phase = 3'h0;
        case ({a_pos, a_neg, b_pos, b_neg})
            4'h8: phase = 3'h0;
            4'ha: phase = 3'h1;
            4'h2: phase = 3'h2;
            4'h6: phase = 3'h3;
            4'h4: phase = 3'h4;
            4'h5: phase = 3'h5;
            4'h1: phase = 3'h6;
            4'h9: phase = 3'h7;
            default: legal = 1'b0;
        endcase
    end
endmodule

// File: verification/srg_step_gen_tb_top.sv
`timescale 1ns/1ns
`define chk(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module srg_step_gen_tb_top;
    localparam int TD = 10;
    logic                             ref_clk, rst, start, half_step, dir, constant_mode;
    logic [srg_pkg::STP_W-1:0]        move_steps;
    logic [15:0]                      accel, decel;
    logic [srg_pkg::DLY_W-1:0]        first_delay, min_delay, step_delay;
    logic                             step_pulse, wind_a_pos, wind_a_neg, wind_b_pos, wind_b_neg, busy, legal;
    logic signed [srg_pkg::POS_W-1:0] position;
    logic [2:0]                       phase;
    int                               mismatches, check_count;

    // A short tick divider keeps the ramp runs brief; every expected gap scales with it.
    srg_step_gen #(.TICK_DIV(TD)) u_dut (.ref_clk(ref_clk), .rst(rst), .start(start), .half_step(half_step),
        .dir(dir), .constant_mode(constant_mode), .move_steps(move_steps), .accel(accel), .decel(decel),
        .first_delay(first_delay), .min_delay(min_delay), .step_pulse(step_pulse), .wind_a_pos(wind_a_pos),
        .wind_a_neg(wind_a_neg), .wind_b_pos(wind_b_pos), .wind_b_neg(wind_b_neg), .position(position),
        .step_delay(step_delay), .busy(busy));
    srg_motor_model u_motor (.a_pos(wind_a_pos), .a_neg(wind_a_neg), .b_pos(wind_b_pos), .b_neg(wind_b_neg),
        .phase(phase), .legal(legal));

    // The clock toggles every half period of 25 ns.
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Waits for the next step pulse under a bound, so a stalled sequencer ends the run.
    task automatic wait_step(output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (step_pulse !== 1'b1 && n < 2000);
        if (step_pulse !== 1'b1) begin
            mismatches++;
            close_out();
        end
    endtask

    // One move: checks delay loading and pulse spacing, and winding order, position and busy at every step.
    task automatic move(input int steps, input logic hs, input logic dr, input logic cm, input int fd);
        int n, ph, inc, d0, dn, skew;
        logic signed [31:0] pos;
        ph = phase;
        pos = position;
        inc = hs ? 1 : 2;
        if (!dr) inc = 8 - inc;
        d0 = cm ? int'(min_delay) : fd * 676 / 1000;
        dn = cm ? d0 : d0 - 2 * d0 / 5;
        @(posedge ref_clk);
        move_steps <= 24'(steps);
        half_step <= hs;
        dir <= dr;
        constant_mode <= cm;
        first_delay <= 16'(fd);
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        #1;
        `chk(busy, 1'b1)
        `chk(step_delay, 16'(d0))
        skew = 0;
        for (int i = 0; i < steps; i++) begin
            wait_step(n);
            // A stimulus edge spent after the previous step belongs to this gap.
            n = n + skew;
            if (i == 0) `chk(n >= d0 * TD - 1 && n <= d0 * TD, 1'b1)
            if (i == 0 || cm) `chk(step_delay, 16'(dn))
            if (i == 1 || (cm && i > 0)) `chk(n, dn * TD)
            ph = (ph + inc) % 8;
            pos = pos + (dr ? 1 : -1);
            `chk(phase, 3'(ph))
            `chk(legal, 1'b1)
            `chk(position, pos)
            `chk(busy, 1'(i != steps - 1))
            // mode and direction flip mid-move, plus a start while busy, must change nothing.
            skew = int'(i == 1 || i == 2);
            if (skew == 1) @(posedge ref_clk);
            if (i == 1) begin
                dir <= ~dr;
                half_step <= ~hs;
                start <= 1'b1;
                // a mid-ramp rate change rescales the ramp index.
                if (!cm) accel <= 16'h00c8;
            end
            if (i == 2) start <= 1'b0;
        end
        repeat (3 * TD) @(posedge ref_clk);
        #1;
        `chk(busy, 1'b0)
        `chk(position, pos)
    endtask

    // Main sequence: reset, constant full-step forward, half-step reverse, ramped move, refused start.
    initial begin
        rst = 1'b1;
        start = 1'b0;
        half_step = 1'b0;
        dir = 1'b1;
        constant_mode = 1'b1;
        move_steps = 24'h000000;
        accel = 16'h0064;
        decel = 16'h0064;
        first_delay = 16'h0000;
        min_delay = 16'h0008;
        mismatches = 0;
        check_count = 0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        `chk(phase, 3'h0)
        `chk(position, 32'sh0)
        `chk(busy, 1'b0)
        move(4, 1'b0, 1'b1, 1'b1, 100);
        move(8, 1'b1, 1'b0, 1'b1, 100);
        // A higher full-speed delay lets the ramp reach the constant-rate stage before decelerating.
        @(posedge ref_clk);
        min_delay <= 16'h001e;
        move(20, 1'b1, 1'b1, 1'b0, 100);
        // A start with a zero-length move is ignored.
        @(posedge ref_clk);
        move_steps <= 24'h000000;
        start <= 1'b1;
        repeat (5) @(posedge ref_clk);
        start <= 1'b0;
        #1;
        `chk(busy, 1'b0)
        close_out();
    end
endmodule
